// [fab_pkg.sv]
// Constants and carrier types shared by the two-level bus fabric.
// Assumes a single clock domain; all masters and slaves are on-chip logic.
package fab_pkg;

	// Backbone, peripheral and external bus widths
	localparam int FAB_DATA_W = 32;
	localparam int FAB_ADDR_W = 32;
	localparam int FAB_PADDR_W = 16;
	localparam int FAB_EADDR_W = 26;
	localparam int FAB_EDATA_W = 16;

	// Memory blocks, chosen by the four top address bits
	localparam logic [3:0] FAB_MB_EXT0 = 4'h0;
	localparam logic [3:0] FAB_MB_EXT1 = 4'h1;
	localparam logic [3:0] FAB_MB_INTMEM = 4'h4;
	localparam logic [3:0] FAB_MB_DSPIF = 4'h5;
	localparam logic [3:0] FAB_MB_VFIFO = 4'h7;
	localparam logic [3:0] FAB_MB_PERIPH = 4'h8;
	localparam logic [3:0] FAB_MB_LCD = 4'h9;

	// Backbone slave select positions
	localparam int FAB_BB_COUNT = 4;
	localparam logic [1:0] FAB_BB_INTMEM = 2'h0;
	localparam logic [1:0] FAB_BB_DSPIF = 2'h1;
	localparam logic [1:0] FAB_BB_VFIFO = 2'h2;
	localparam logic [1:0] FAB_BB_LCD = 2'h3;

	// Peripheral windows: 64KB each, index taken from address bits above the offset
	localparam int FAB_PSEL_W = 6;
	localparam int FAB_PSEL_COUNT = 64;
	localparam int FAB_PSEL_LSB = 16;
	// One bit per peripheral window: set for 32-bit data path, clear for 16-bit
	localparam logic [63:0] FAB_PERIPH_WIDE = 64'h0000_0325_0080_024e;

	localparam int FAB_DMA_CHANNELS = 13;
	localparam int FAB_IRQ_COUNT = 32;

	// Transfer sizes
	localparam logic [1:0] FAB_SIZE_BYTE = 2'h0;
	localparam logic [1:0] FAB_SIZE_HALF = 2'h1;
	localparam logic [1:0] FAB_SIZE_WORD = 2'h2;

	localparam logic FAB_OWNER_CPU = 1'b0;
	localparam logic FAB_OWNER_DMA = 1'b1;

	typedef enum logic [2:0] {
		FAB_IDLE = 3'h0,
		FAB_BB = 3'h1,
		FAB_PSETUP = 3'h2,
		FAB_PACCESS = 3'h3,
		FAB_EXT = 3'h4,
		FAB_DONE = 3'h5,
		FAB_PWAKE = 3'h6
	} fab_phase_type;

	typedef struct packed {
		logic req;
		logic write;
		logic [1:0] size;
		logic [3:0] chan;
		logic [31:0] addr;
		logic [31:0] wdata;
	} fab_mreq_type;

	typedef struct packed {
		logic gnt;
		logic ready;
		logic err;
		logic [31:0] rdata;
	} fab_mrsp_type;

	typedef struct packed {
		logic [3:0] sel;
		logic master;
		logic [3:0] chan;
		logic write;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} fab_bb_type;

	typedef struct packed {
		logic pclk_en;
		logic [63:0] psel;
		logic penable;
		logic pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} fab_apb_type;

	typedef struct packed {
		logic req;
		logic [3:0] cs;
		logic [25:0] addr;
		logic write;
		logic wide;
		logic sync;
		logic burst_cont;
		logic [15:0] wdata;
	} fab_ext_type;

endpackage

// [fab_fabric.sv]
// Two-level bus fabric: arbiter, central decoder, backbone mux,
// peripheral bridge with clock gating, external memory splitter and
// interrupt request routing.
// Assumes masters hold a request stable until answered; all on one clock.
//
// Overview of operation
// - Transfers start only from a master; slaves merely answer presented requests.
// - Masters request the bus and wait for grant before transferring.
// - Backbone carries 32-bit data, steered by multiplexers, not tri-states.
// - Peripheral bus gives 16-bit addresses; slaves may be 16 or 32 bits wide.
// - Peripheral clock off when idle, restored before the next transfer.
// - Backbone targets complete on the backbone without the bridge.
// - Peripheral targets: bridge performs the access, then completes the backbone transfer.
// - All modules reached through one 32-bit memory address space only.
// - Central decoder gives one select per backbone module.
// - DMA is a second master with thirteen channels.
// - Interrupt routing accepts up to 32 simultaneous sources.
// - Interrupts reach the processor as fast and normal requests.
// - Internal RAM and boot ROM share one internal memory slave port.
// - External accesses split into 8-bit or 16-bit cycles by device width.
// - External interface serves sync and async devices, page and burst flash.
// - Processor memory port attaches directly as a backbone master.
// - Decoder picks a 256MB block from the four top address bits.
// - Peripherals occupy one block; the bridge decodes individual peripheral selects.
// - Peripheral address carries only the window offset; windows at most 64KB.
`timescale 1ns/10ps
`default_nettype none
module fab_fabric #(
	parameter logic [63:0] PERIPH_WIDE = fab_pkg::FAB_PERIPH_WIDE,
	parameter int DMA_CHANNELS = fab_pkg::FAB_DMA_CHANNELS
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Masters
	input wire fab_pkg::fab_mreq_type cpu_req,
	output fab_pkg::fab_mrsp_type cpu_rsp,
	input wire fab_pkg::fab_mreq_type dma_req,
	output fab_pkg::fab_mrsp_type dma_rsp,
	// Backbone slaves
	output fab_pkg::fab_bb_type bb_out,
	input wire logic [3:0] bb_ready,
	input wire logic [3:0][31:0] bb_rdata,
	input wire logic intmem_rom,
	// Peripheral bus
	output fab_pkg::fab_apb_type apb_out,
	input wire logic [63:0] pready,
	input wire logic [63:0][31:0] prdata,
	// External memory
	output fab_pkg::fab_ext_type ext_out,
	input wire logic ext_ready,
	input wire logic [15:0] ext_rdata,
	input wire logic [3:0] ext_bank_wide,
	input wire logic [3:0] ext_bank_sync,
	// Interrupts
	input wire logic [31:0] irq_src,
	input wire logic [31:0] irq_fast_route,
	output logic irq_fast,
	output logic irq_normal
);

	typedef struct packed {
		fab_pkg::fab_phase_type phase;
		logic owner;
		logic [3:0] chan;
		logic write;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic err;
		logic [1:0] bb_idx;
		logic [3:0] bb_sel;
		logic [63:0] psel;
		logic penable;
		logic pclk_en;
		logic ext_req;
		logic [1:0] ext_beat;
		logic [1:0] ext_last;
		logic [3:0] ext_cs;
		logic [25:0] ext_addr;
		logic [15:0] ext_wdata;
		logic ext_wide;
		logic ext_sync;
		logic irq_fast;
		logic irq_normal;
	} fab_state_type;

	fab_state_type st;
	fab_state_type next_st;
	fab_pkg::fab_mreq_type mreq;
	logic [5:0] pidx;
	logic [1:0] ecs_idx;
	logic [1:0] lane;
	logic [1:0] next_lane;
	logic [31:0] shifted;

	// Owner's request steers the backbone; processor port used as is
	assign mreq = (st.owner == fab_pkg::FAB_OWNER_DMA) ? dma_req : cpu_req;
	assign pidx = st.addr[fab_pkg::FAB_PSEL_LSB +: fab_pkg::FAB_PSEL_W];
	assign ecs_idx = mreq.addr[28:27];
	assign lane = st.ext_addr[1:0];

	always_comb begin
		next_st = st;
		next_lane = 2'h0;
		shifted = 32'h0;
		// Interrupt sources split between fast and normal lines
		next_st.irq_fast = |(irq_src & irq_fast_route);
		next_st.irq_normal = |(irq_src & ~irq_fast_route);
		case (st.phase)
			fab_pkg::FAB_IDLE: begin
				if (mreq.req) begin
					next_st.write = mreq.write;
					next_st.size = mreq.size;
					next_st.addr = mreq.addr;
					next_st.wdata = mreq.wdata;
					next_st.chan = mreq.chan;
					next_st.err = 1'b0;
					next_st.rdata = 32'h0;
					next_st.phase = fab_pkg::FAB_DONE;
					if (st.owner == fab_pkg::FAB_OWNER_DMA && mreq.chan >= 4'(DMA_CHANNELS)) begin
						next_st.err = 1'b1;
					end else begin
						// Block picked from top address bits; no I/O space exists
						case (mreq.addr[31:28])
							fab_pkg::FAB_MB_EXT0, fab_pkg::FAB_MB_EXT1: begin
								next_st.phase = fab_pkg::FAB_EXT;
								next_st.ext_req = 1'b1;
								next_st.ext_beat = 2'h0;
								next_st.ext_cs = 4'h1 << ecs_idx;
								next_st.ext_wide = ext_bank_wide[ecs_idx];
								next_st.ext_sync = ext_bank_sync[ecs_idx];
								next_st.ext_addr = mreq.addr[25:0];
								shifted = mreq.wdata >> {mreq.addr[1:0], 3'h0};
								next_st.ext_wdata = shifted[15:0];
								case (mreq.size)
									fab_pkg::FAB_SIZE_BYTE: next_st.ext_last = 2'h0;
									fab_pkg::FAB_SIZE_HALF: next_st.ext_last = {1'b0, ~ext_bank_wide[ecs_idx]};
									default: next_st.ext_last = ext_bank_wide[ecs_idx] ? 2'h1 : 2'h3;
								endcase
							end
							fab_pkg::FAB_MB_INTMEM: begin
								// RAM and ROM halves share the one port
								next_st.phase = fab_pkg::FAB_BB;
								next_st.bb_idx = fab_pkg::FAB_BB_INTMEM;
							end
							fab_pkg::FAB_MB_DSPIF: begin
								next_st.phase = fab_pkg::FAB_BB;
								next_st.bb_idx = fab_pkg::FAB_BB_DSPIF;
							end
							fab_pkg::FAB_MB_VFIFO: begin
								if (mreq.addr[27]) begin
									next_st.phase = fab_pkg::FAB_BB;
									next_st.bb_idx = fab_pkg::FAB_BB_VFIFO;
								end else begin
									next_st.err = 1'b1;
								end
							end
							fab_pkg::FAB_MB_LCD: begin
								if (!mreq.addr[27]) begin
									next_st.phase = fab_pkg::FAB_BB;
									next_st.bb_idx = fab_pkg::FAB_BB_LCD;
								end else begin
									next_st.err = 1'b1;
								end
							end
							fab_pkg::FAB_MB_PERIPH: begin
								if (mreq.addr[27:22] == 6'h0) begin
									// Clock wakes one cycle ahead of the setup phase
									next_st.phase = fab_pkg::FAB_PWAKE;
									next_st.pclk_en = 1'b1;
								end else begin
									next_st.err = 1'b1;
								end
							end
							default: next_st.err = 1'b1;
						endcase
						if (next_st.phase == fab_pkg::FAB_BB) begin
							next_st.bb_sel = 4'h1 << next_st.bb_idx;
						end
					end
				end else begin
					// No pending transfer from owner: hand over, processor by default
					next_st.owner = dma_req.req ? fab_pkg::FAB_OWNER_DMA : fab_pkg::FAB_OWNER_CPU;
				end
			end
			fab_pkg::FAB_BB: begin
				if (bb_ready[st.bb_idx]) begin
					next_st.rdata = bb_rdata[st.bb_idx];
					next_st.bb_sel = 4'h0;
					next_st.phase = fab_pkg::FAB_DONE;
				end
			end
			fab_pkg::FAB_PWAKE: begin
				next_st.psel = 64'h1 << pidx;
				next_st.phase = fab_pkg::FAB_PSETUP;
			end
			fab_pkg::FAB_PSETUP: begin
				next_st.penable = 1'b1;
				next_st.phase = fab_pkg::FAB_PACCESS;
			end
			fab_pkg::FAB_PACCESS: begin
				if (pready[pidx]) begin
					// Narrow peripherals return only the low half
					next_st.rdata = PERIPH_WIDE[pidx] ? prdata[pidx] : {16'h0, prdata[pidx][15:0]};
					next_st.psel = 64'h0;
					next_st.penable = 1'b0;
					next_st.pclk_en = 1'b0;
					next_st.phase = fab_pkg::FAB_DONE;
				end
			end
			fab_pkg::FAB_EXT: begin
				if (ext_ready) begin
					next_st.rdata[{lane, 3'h0} +: 8] = ext_rdata[7:0];
					if (st.ext_wide) begin
						next_lane = lane + 2'h1;
						next_st.rdata[{next_lane, 3'h0} +: 8] = ext_rdata[15:8];
					end
					if (st.ext_beat == st.ext_last) begin
						next_st.ext_req = 1'b0;
						next_st.phase = fab_pkg::FAB_DONE;
					end else begin
						// Following cycles are page or burst continuations
						next_st.ext_beat = st.ext_beat + 2'h1;
						next_st.ext_addr = st.ext_addr + (st.ext_wide ? 26'h2 : 26'h1);
						next_lane = st.ext_addr[1:0] + (st.ext_wide ? 2'h2 : 2'h1);
						shifted = st.wdata >> {next_lane, 3'h0};
						next_st.ext_wdata = shifted[15:0];
					end
				end
			end
			fab_pkg::FAB_DONE: begin
				next_st.phase = fab_pkg::FAB_IDLE;
				// Alternate ownership when the other master waits
				if (st.owner == fab_pkg::FAB_OWNER_CPU) begin
					next_st.owner = dma_req.req ? fab_pkg::FAB_OWNER_DMA : fab_pkg::FAB_OWNER_CPU;
				end else begin
					next_st.owner = cpu_req.req ? fab_pkg::FAB_OWNER_CPU : fab_pkg::FAB_OWNER_DMA;
				end
			end
			default: next_st.phase = fab_pkg::FAB_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Master answers
	always_comb begin
		cpu_rsp.gnt = (st.owner == fab_pkg::FAB_OWNER_CPU);
		cpu_rsp.ready = (st.phase == fab_pkg::FAB_DONE) && (st.owner == fab_pkg::FAB_OWNER_CPU);
		cpu_rsp.err = st.err;
		cpu_rsp.rdata = st.rdata;
		dma_rsp.gnt = (st.owner == fab_pkg::FAB_OWNER_DMA);
		dma_rsp.ready = (st.phase == fab_pkg::FAB_DONE) && (st.owner == fab_pkg::FAB_OWNER_DMA);
		dma_rsp.err = st.err;
		dma_rsp.rdata = st.rdata;
	end

	// Slave sides
	always_comb begin
		bb_out.sel = st.bb_sel;
		bb_out.master = st.owner;
		bb_out.chan = st.chan;
		bb_out.write = st.write;
		bb_out.size = st.size;
		bb_out.addr = st.addr;
		bb_out.wdata = st.wdata;
		apb_out.pclk_en = st.pclk_en;
		apb_out.psel = st.psel;
		apb_out.penable = st.penable;
		apb_out.pwrite = st.write;
		apb_out.paddr = st.addr[15:0];
		apb_out.pwdata = st.wdata;
		ext_out.req = st.ext_req;
		ext_out.cs = st.ext_req ? st.ext_cs : 4'h0;
		ext_out.addr = st.ext_addr;
		ext_out.write = st.write;
		ext_out.wide = st.ext_wide;
		ext_out.sync = st.ext_sync;
		ext_out.burst_cont = st.ext_req && (st.ext_beat != 2'h0);
		ext_out.wdata = st.ext_wdata;
		irq_fast = st.irq_fast;
		irq_normal = st.irq_normal;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_default_owner;
		(st.phase == fab_pkg::FAB_IDLE) && !st.ext_req && !cpu_req.req && !dma_req.req
			|=> cpu_rsp.gnt && !dma_rsp.gnt;
	endproperty
	a_default_owner: assert property (p_default_owner) else $error("processor not default owner");

	property p_grant_steady;
		(st.phase != fab_pkg::FAB_IDLE) && (st.phase != fab_pkg::FAB_DONE) |=> $stable(st.owner);
	endproperty
	a_grant_steady: assert property (p_grant_steady) else $error("owner changed mid transfer");

	property p_clock_before_setup;
		(|apb_out.psel && !apb_out.penable) |-> $past(apb_out.pclk_en) && apb_out.pclk_en;
	endproperty
	a_clock_before_setup: assert property (p_clock_before_setup) else $error("clock not restored");

	property p_clock_off_idle;
		(st.phase == fab_pkg::FAB_IDLE) || (st.phase == fab_pkg::FAB_BB) |-> !apb_out.pclk_en;
	endproperty
	a_clock_off_idle: assert property (p_clock_off_idle) else $error("peripheral clock left on");

	property p_apb_sequence;
		(|apb_out.psel && !apb_out.penable) |=> apb_out.penable && (apb_out.psel == $past(apb_out.psel));
	endproperty
	a_apb_sequence: assert property (p_apb_sequence) else $error("bad access phase");

	property p_apb_finish;
		apb_out.penable && pready[pidx] |=> (cpu_rsp.ready || dma_rsp.ready) && !(|apb_out.psel);
	endproperty
	a_apb_finish: assert property (p_apb_finish) else $error("bridge did not complete");

	property p_selects;
		$onehot0(bb_out.sel) && $onehot0(apb_out.psel) && !(|bb_out.sel && |apb_out.psel);
	endproperty
	a_selects: assert property (p_selects) else $error("selects not exclusive");

	property p_bb_direct;
		|bb_out.sel |-> !apb_out.pclk_en ##0 (bb_out.addr[31:28] != fab_pkg::FAB_MB_PERIPH);
	endproperty
	a_bb_direct: assert property (p_bb_direct) else $error("backbone used bridge");

	property p_ext_split;
		ext_out.req && ext_ready && (st.ext_beat != st.ext_last) |=> ext_out.req && ext_out.burst_cont;
	endproperty
	a_ext_split: assert property (p_ext_split) else $error("external cycle dropped");

	property p_irq_route;
		|(irq_src & ~irq_fast_route) |=> irq_normal;
	endproperty
	a_irq_route: assert property (p_irq_route) else $error("normal request missing");

	property p_ready_pulse;
		cpu_rsp.ready |=> !cpu_rsp.ready && !dma_rsp.ready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");

	c_apb_transfer: cover property (apb_out.penable && pready[pidx]);
	c_ext_multi: cover property (ext_out.burst_cont && ext_ready);
	c_dma_grant: cover property (dma_rsp.gnt && dma_rsp.ready);

endmodule
`default_nettype wire

// [fab_slave_model.sv]
// Behavioural slaves behind the fabric: backbone, peripheral and external devices.
// Assumes the fabric holds each select or beat until the matching ready returns.
`timescale 1ns/10ps
`default_nettype none
module fab_slave_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Answer delay in cycles
	input wire logic [1:0] wait_n,
	// Backbone slaves
	input wire fab_pkg::fab_bb_type bb_out,
	output logic [3:0] bb_ready,
	output logic [3:0][31:0] bb_rdata,
	// Peripheral slaves
	input wire fab_pkg::fab_apb_type apb_out,
	output logic [63:0] pready,
	output logic [63:0][31:0] prdata,
	// External devices
	input wire fab_pkg::fab_ext_type ext_out,
	output logic ext_ready,
	output logic [15:0] ext_rdata
);
	logic [2:0] cnt;
	logic act;
	logic go;
	logic [31:0] ed;
	function automatic logic [31:0] pat(input logic [31:0] a);
		return a ^ 32'h5a5a_c3c3 ^ {a[15:0], a[31:16]};
	endfunction
	assign act = (|bb_out.sel) | apb_out.penable | ext_out.req;
	assign go = act && ({1'b0, wait_n} <= cnt);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 3'h0;
		end else begin
			cnt <= (act && !go) ? cnt + 3'h1 : 3'h0;
		end
	end
	// Slaves answer only what is presented; lines not answering show the inverse
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			bb_ready[i] = go && bb_out.sel[i];
			bb_rdata[i] = bb_ready[i] ? pat(bb_out.addr) : ~pat(bb_out.addr);
		end
		for (int i = 0; i < 64; i++) begin
			pready[i] = go && apb_out.psel[i] && apb_out.penable && apb_out.pclk_en;
			prdata[i] = pat({10'h200, 6'(i), apb_out.paddr});
			if (!pready[i]) begin
				prdata[i] = ~prdata[i];
			end
		end
		ext_ready = go && ext_out.req;
		ed = pat({6'h00, ext_out.addr});
		ext_rdata = ext_ready ? ed[15:0] : ~ed[15:0];
	end
endmodule
`default_nettype wire

// [test_fab_fabric.sv]
// Self-checking bench for the bus fabric with random traffic from both masters.
// Assumes the slave model answers with a randomly varying delay.
`timescale 1ns/10ps
`default_nettype none
module test_fab_fabric;
	localparam int DLY = 10;
	// Top nibbles of blocks that hold no module
	localparam logic [31:0] BAD_BLOCKS = 32'hfdcb_a632;
	fab_pkg::fab_mreq_type own;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	fab_pkg::fab_mreq_type cpu_req = '0;
	fab_pkg::fab_mreq_type dma_req = '0;
	fab_pkg::fab_mrsp_type cpu_rsp;
	fab_pkg::fab_mrsp_type dma_rsp;
	fab_pkg::fab_bb_type bb_out;
	fab_pkg::fab_apb_type apb_out;
	fab_pkg::fab_ext_type ext_out;
	logic [3:0] bb_ready;
	logic [3:0][31:0] bb_rdata;
	logic [63:0] pready;
	logic [63:0][31:0] prdata;
	logic ext_ready;
	logic [15:0] ext_rdata;
	logic [3:0] ext_bank_wide = 4'h0;
	logic [3:0] ext_bank_sync = 4'h0;
	logic [31:0] irq_src = 32'h0;
	logic [31:0] irq_fast_route = 32'h0;
	logic irq_fast;
	logic irq_normal;
	logic [1:0] wait_n = 2'h0;
	logic [31:0] seed = 32'h0000_9264;
	int num_errors = 0;
	int n_compared = 0;
	fab_fabric DUT (.clock(clock), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
		.dma_req(dma_req), .dma_rsp(dma_rsp), .bb_out(bb_out), .bb_ready(bb_ready),
		.bb_rdata(bb_rdata), .intmem_rom(1'b0), .apb_out(apb_out), .pready(pready),
		.prdata(prdata), .ext_out(ext_out), .ext_ready(ext_ready), .ext_rdata(ext_rdata),
		.ext_bank_wide(ext_bank_wide), .ext_bank_sync(ext_bank_sync), .irq_src(irq_src),
		.irq_fast_route(irq_fast_route), .irq_fast(irq_fast), .irq_normal(irq_normal));
	fab_slave_model slaves (.clock(clock), .rst_n(rst_n), .wait_n(wait_n), .bb_out(bb_out),
		.bb_ready(bb_ready), .bb_rdata(bb_rdata), .apb_out(apb_out), .pready(pready),
		.prdata(prdata), .ext_out(ext_out), .ext_ready(ext_ready), .ext_rdata(ext_rdata));
	always #50 clock = ~clock;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] pat(input logic [31:0] a);
		return a ^ 32'h5a5a_c3c3 ^ {a[15:0], a[31:16]};
	endfunction
	// Expected {err, rdata} of a read of the given size
	function automatic logic [32:0] expect_rd(input logic [3:0] ch, input logic [1:0] sz,
		input logic [31:0] a);
		logic [31:0] d;
		logic [31:0] t;
		logic w;
		int nb;
		d = pat(a);
		w = ext_bank_wide[a[28:27]];
		// Bytes filled by the external beats that the size needs on this width
		nb = (sz == fab_pkg::FAB_SIZE_WORD) ? 4 : (w || sz == fab_pkg::FAB_SIZE_HALF) ? 2 : 1;
		if (ch >= 4'hd) begin
			return {1'b1, 32'h0};
		end
		case (a[31:28])
			4'h4, 4'h5: return {1'b0, d};
			4'h7: return a[27] ? {1'b0, d} : {1'b1, 32'h0};
			4'h9: return a[27] ? {1'b1, 32'h0} : {1'b0, d};
			4'h8: begin
				if (fab_pkg::FAB_PERIPH_WIDE[a[21:16]] == 1'b0) d[31:16] = 16'h0;
				return (a <= 32'h803f_ffff) ? {1'b0, d} : {1'b1, 32'h0};
			end
			4'h0, 4'h1: begin
				for (int n = 0; n < 4; n++) begin
					t = pat({6'h00, a[25:0]} + (w ? 32'(n & 2) : 32'(n)));
					d[8*n +: 8] = (n >= nb) ? 8'h0 : w ? t[8*(n%2) +: 8] : t[7:0];
				end
				return {1'b0, d};
			end
			default: return {1'b1, 32'h0};
		endcase
	endfunction
	function automatic logic [3:0] sel_of(input logic [3:0] b);
		case (b)
			4'h4: return 4'h1;
			4'h5: return 4'h2;
			4'h7: return 4'h4;
			4'h9: return 4'h8;
			default: return 4'h0;
		endcase
	endfunction
	task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic access(input logic m, input logic [3:0] ch, input logic [31:0] a);
		fab_pkg::fab_mreq_type q;
		fab_pkg::fab_mrsp_type p;
		logic [32:0] ex;
		logic [31:0] r;
		logic [1:0] sz;
		int n;
		r = rnd();
		sz = (r[2:1] == 2'h3) ? fab_pkg::FAB_SIZE_WORD : r[2:1];
		q = '{req: 1'b1, write: r[0], size: sz, chan: ch, addr: a, wdata: rnd()};
		ex = expect_rd(ch, sz, a);
		@(posedge clock);
		#DLY;
		if (m) dma_req = q; else cpu_req = q;
		n = 0;
		do begin
			@(negedge clock);
			n++;
			p = m ? dma_rsp : cpu_rsp;
		end while (p.ready !== 1'b1 && n < 400);
		if (p.ready !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: no ready", $time);
			report_and_stop();
		end
		chk_flag(p.err, ex[32]);
		if (!r[0] || ex[32]) chk_val(64'(p.rdata), 64'(ex[31:0]));
		chk_flag(apb_out.pclk_en, 1'b0);
		@(posedge clock);
		#DLY;
		q.req = 1'b0;
		if (m) dma_req = q; else cpu_req = q;
	endtask
	task automatic run(input logic m, input int cnt);
		logic [31:0] r;
		logic [31:0] s;
		logic [31:0] a;
		logic [5:0] idx;
		for (int k = 0; k < cnt; k++) begin
			r = rnd();
			s = rnd();
			idx = s[21:16];
			// Half the peripheral accesses seek a wide window, the rest stay as drawn
			for (int j = 0; j < 64 && s[31] && !fab_pkg::FAB_PERIPH_WIDE[idx]; j++) idx++;
			case (r[2:0])
				3'h0: a = {4'h4, s[27:0]};
				3'h1: a = {4'h5, s[27:0]};
				3'h2: a = {5'h0f, s[26:0]};
				3'h3: a = {5'h12, s[26:0]};
				3'h4: a = {10'h200, idx, s[15:0]};
				3'h5, 3'h6: a = {3'h0, s[28:0]};
				default: a = s[31] ? (s[0] ? 32'h8040_0000 : 32'h77ff_fffc) :
					{BAD_BLOCKS[4*s[30:28] +: 4], s[27:0]};
			endcase
			a[1:0] = 2'b00;
			access(m, m ? r[7:4] : 4'h0, a);
		end
	endtask
	always begin
		@(posedge clock);
		#DLY;
		wait_n = seed[1:0];
	end
	always @(negedge clock) begin
		own = dma_rsp.gnt ? dma_req : cpu_req;
		if (rst_n) begin
			if (|bb_out.sel) chk_val(64'(bb_out.wdata), 64'(own.wdata));
			if (|apb_out.psel) chk_val(apb_out.psel, 64'h1 << own.addr[21:16]);
			if (|apb_out.psel) chk_val(64'(apb_out.paddr), 64'(own.addr[15:0]));
			if (ext_out.req) chk_val(64'(ext_out.cs), 64'(4'h1 << own.addr[28:27]));
			chk_flag(cpu_rsp.gnt & dma_rsp.gnt, 1'b0);
			if (cpu_rsp.ready) chk_flag(cpu_req.req & cpu_rsp.gnt, 1'b1);
			if (dma_rsp.ready) chk_flag(dma_req.req & dma_rsp.gnt, 1'b1);
			if (|bb_out.sel) chk_val(64'(bb_out.sel), 64'(sel_of(bb_out.addr[31:28])));
			if (|bb_out.sel) chk_val(apb_out.psel, 64'h0);
			if (|apb_out.psel) chk_flag(apb_out.pclk_en, 1'b1);
		end
	end
	initial begin
		logic [31:0] r;
		repeat (20) @(posedge clock);
		#DLY;
		rst_n = 1'b1;
		r = rnd();
		ext_bank_wide = r[3:0];
		ext_bank_sync = r[7:4];
		@(negedge clock);
		chk_flag(cpu_rsp.gnt, 1'b1);
		fork
			run(1'b0, 60);
			run(1'b1, 60);
		join
		for (int k = 0; k < 20; k++) begin
			@(posedge clock);
			#DLY;
			irq_src = (k == 0) ? 32'hffff_ffff : rnd();
			irq_fast_route = (k == 1) ? 32'h0 : rnd();
			@(posedge clock);
			@(negedge clock);
			chk_flag(irq_fast, |(irq_src & irq_fast_route));
			chk_flag(irq_normal, |(irq_src & ~irq_fast_route));
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
